// ==== rtl/spi_port_defs.svh ====
// register addresses, field positions, reset values and timing counts of the serial port
// assumes inclusion by its bare name from the package and the design file
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// ***********************************************
// register addresses
// ***********************************************
`define SPI_ADDR_CONFIG 8'h9a
`define SPI_ADDR_DATA 8'h9b
`define SPI_ADDR_DIVIDER 8'h9d

// ***********************************************
// field positions of serial_port_config
// ***********************************************
`define SPI_CFG_PHASE_BIT 7
`define SPI_CFG_POLARITY_BIT 6
`define SPI_CFG_COUNT_HI 5
`define SPI_CFG_COUNT_LO 3
`define SPI_CFG_FRAME_HI 2
`define SPI_CFG_FRAME_LO 0

// ***********************************************
// reset values
// ***********************************************
`define SPI_CONFIG_RESET 8'h07
`define SPI_DATA_RESET 8'h00
`define SPI_DIVIDER_RESET 8'h00

// ***********************************************
// timing
// ***********************************************
// system clock period in ns, and fewest clock cycles per serial clock half period
`define SPI_SYSTEM_CLOCK_PERIOD_NS 100
`define SPI_MIN_HALF_PERIOD_CYCLES 1
// frame length that a slave always uses
`define SPI_SLAVE_FRAME_BITS 4'h8

`endif

// ==== rtl/spi_port_pkg.sv ====
// types shared by the serial peripheral port
// assumes the constants header is on the include path
package spi_port_pkg;

	`include "spi_port_defs.svh"

	// software visible configuration fields
	typedef struct packed {
		logic clock_phase_sel;
		logic clock_polarity_sel;
		logic [2:0] frame_length_sel;
	} port_cfg_s;

	// master transfer engine
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RUN
	} master_state_e;

endpackage

// ==== rtl/spi_port.sv ====
// serial peripheral port: master or slave, one to eight bit frames, receive fifo
// assumes all pins and the register strobes are synchronous to CLK_IN
//
// Notes on behaviour
// - runs as clock driving master or slave
// - only the selected slave exchanges data
// - foreign select during master use flags collision
// - master bit rate at most half system clock
// - slave receives at up to half clock
// - phase bit picks first or second sampling edge
// - polarity bit sets serial clock idle level
// - read only counter shows bits transmitted
// - master frame length is field plus one
// - slave ignores the frame length field
// - master clock is half clock over divider+1
// - data write when not busy loads shifter, master starts transfer if the foreign select is high and the fifo has room
// - data read returns the receive buffer
// - config resets to 07, others to zero
`timescale 1ns/1ps

`include "spi_port_defs.svh"

// ***********************************************
// receive fifo
// ***********************************************
module spi_rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_INDEX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != FULL_COUNT);
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST_INDEX) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST_INDEX) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

// ***********************************************
// port top
// ***********************************************
module spi_port
	import spi_port_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	// mode control
	input wire logic ENABLE_IN,
	input wire logic MASTER_MODE_IN,
	// special function register port
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic SFR_WR_IN,
	input wire logic SFR_RD_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	output logic [7:0] SFR_RDATA_OUT,
	// status flags
	output logic BUSY_OUT,
	output logic DONE_OUT,
	input wire logic DONE_CLR_IN,
	output logic COLLISION_OUT,
	input wire logic COLLISION_CLR_IN,
	// received word stream
	output logic RX_VALID_OUT,
	input wire logic RX_READY_IN,
	output logic [7:0] RX_DATA_OUT,
	// serial pins
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	input wire logic MOSI_IN,
	output logic MOSI_OUT,
	output logic MOSI_OE_OUT,
	input wire logic MISO_IN,
	output logic MISO_OUT,
	output logic MISO_OE_OUT,
	input wire logic SLAVE_SELECT_N_IN,
	output logic SLAVE_SELECT_N_OUT
);
	localparam logic [3:0] SLAVE_BITS = `SPI_SLAVE_FRAME_BITS;
	localparam logic [7:0] CFG_RESET = `SPI_CONFIG_RESET;

	port_cfg_s cfg_q;
	logic [7:0] clock_divide_value_q;
	logic [7:0] shift_q;
	logic [7:0] rx_buf_q;
	logic [7:0] rdata_q;
	logic [2:0] bit_progress_count_q;
	logic [7:0] div_cnt_q;
	logic sclk_q;
	logic in_bit_q;
	logic out_q;
	logic sck_prev_q;
	logic done_q;
	logic collision_q;
	master_state_e state_q;

	logic is_master;
	logic selected;
	logic tick;
	logic lead_ev;
	logic trail_ev;
	logic ser_in;
	logic shift_in_bit;
	logic [3:0] frame_bits;
	logic last_bit;
	logic frame_end;
	logic busy;
	logic data_wr;
	logic start;
	logic clash;
	logic fifo_ready;

	assign is_master = ENABLE_IN & MASTER_MODE_IN;
	// only a slave whose select is low takes part
	assign selected = ENABLE_IN & ~MASTER_MODE_IN & ~SLAVE_SELECT_N_IN;
	assign clash = is_master & ~SLAVE_SELECT_N_IN;
	assign data_wr = SFR_WR_IN & (SFR_ADDR_IN == `SPI_ADDR_DATA);
	assign busy = (state_q == ST_RUN) | (selected & (bit_progress_count_q != 3'h0));
	// a full fifo holds back the next master transfer
	assign start = data_wr & is_master & ~busy & ~clash & fifo_ready;

	// ***********************************************
	// master clock divider
	// ***********************************************
	// a tick every divider+1 cycles, one serial clock half period each
	assign tick = (state_q == ST_RUN) & (div_cnt_q == clock_divide_value_q);

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			div_cnt_q <= 8'h00;
		end else if (start || tick) begin
			div_cnt_q <= 8'h00;
		end else if (state_q == ST_RUN) begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	// ***********************************************
	// edge events
	// ***********************************************
	// slave edges come from the sampled pin, so one cycle per level is enough to receive
	always_comb begin
		lead_ev = 1'b0;
		trail_ev = 1'b0;
		if (is_master) begin
			lead_ev = tick & ~sclk_q;
			trail_ev = tick & sclk_q;
		end else if (selected) begin
			lead_ev = (SCK_IN != cfg_q.clock_polarity_sel) & (sck_prev_q == cfg_q.clock_polarity_sel);
			trail_ev = (SCK_IN == cfg_q.clock_polarity_sel) & (sck_prev_q != cfg_q.clock_polarity_sel);
		end
	end

	assign ser_in = is_master ? MISO_IN : MOSI_IN;
	// phase 0 samples on the leading edge, phase 1 on the trailing edge
	assign shift_in_bit = cfg_q.clock_phase_sel ? ser_in : in_bit_q;
	assign frame_bits = is_master ? {1'b0, cfg_q.frame_length_sel} + 4'h1 : SLAVE_BITS;
	assign last_bit = ({1'b0, bit_progress_count_q} == (frame_bits - 4'h1));
	assign frame_end = trail_ev & last_bit;

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= SCK_IN;
		end
	end

	// ***********************************************
	// master state
	// ***********************************************
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (clash || !is_master || frame_end) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sclk_q <= 1'b0;
		end else if (state_q != ST_RUN || clash) begin
			sclk_q <= 1'b0;
		end else if (tick) begin
			sclk_q <= ~sclk_q;
		end
	end

	// ***********************************************
	// shifter and bit counter
	// ***********************************************
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			shift_q <= `SPI_DATA_RESET;
		end else if (data_wr && !busy) begin
			shift_q <= SFR_WDATA_IN;
		end else if (trail_ev) begin
			shift_q <= {shift_q[6:0], shift_in_bit};
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			in_bit_q <= 1'b0;
		end else if (lead_ev) begin
			in_bit_q <= ser_in;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			bit_progress_count_q <= 3'h0;
		end else if (start || frame_end || (!is_master && !selected) || (state_q == ST_RUN && clash)) begin
			bit_progress_count_q <= 3'h0;
		end else if (trail_ev) begin
			bit_progress_count_q <= bit_progress_count_q + 3'h1;
		end
	end

	// outgoing bit changes on the edge opposite the sampling one
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			out_q <= 1'b0;
		end else if (start) begin
			out_q <= SFR_WDATA_IN[7];
		end else if (!is_master && !selected) begin
			out_q <= shift_q[7];
		end else if (cfg_q.clock_phase_sel ? lead_ev : trail_ev) begin
			out_q <= cfg_q.clock_phase_sel ? shift_q[7] : shift_q[6];
		end
	end

	// ***********************************************
	// receive buffer, fifo and flags
	// ***********************************************
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rx_buf_q <= `SPI_DATA_RESET;
		end else if (frame_end) begin
			rx_buf_q <= {shift_q[6:0], shift_in_bit};
		end
	end

	// a slave word that meets a full fifo is kept only in the receive buffer
	spi_rx_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(CLK_IN),
		.nrst(NRST_IN),
		.in_valid(frame_end),
		.in_ready(fifo_ready),
		.in_data({shift_q[6:0], shift_in_bit}),
		.out_valid(RX_VALID_OUT),
		.out_ready(RX_READY_IN),
		.out_data(RX_DATA_OUT)
	);

	// set wins over a clear in the same cycle
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			done_q <= 1'b0;
		end else if (frame_end) begin
			done_q <= 1'b1;
		end else if (DONE_CLR_IN) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			collision_q <= 1'b0;
		end else if ((state_q == ST_RUN || data_wr) && clash) begin
			collision_q <= 1'b1;
		end else if (COLLISION_CLR_IN) begin
			collision_q <= 1'b0;
		end
	end

	// ***********************************************
	// register port
	// ***********************************************
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cfg_q <= port_cfg_s'({CFG_RESET[7:6], CFG_RESET[2:0]});
			clock_divide_value_q <= `SPI_DIVIDER_RESET;
		end else if (SFR_WR_IN) begin
			if (SFR_ADDR_IN == `SPI_ADDR_CONFIG) begin
				cfg_q.clock_phase_sel <= SFR_WDATA_IN[`SPI_CFG_PHASE_BIT];
				cfg_q.clock_polarity_sel <= SFR_WDATA_IN[`SPI_CFG_POLARITY_BIT];
				cfg_q.frame_length_sel <= SFR_WDATA_IN[`SPI_CFG_FRAME_HI:`SPI_CFG_FRAME_LO];
			end
			if (SFR_ADDR_IN == `SPI_ADDR_DIVIDER) begin
				clock_divide_value_q <= SFR_WDATA_IN;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_q <= 8'h00;
		end else if (SFR_RD_IN) begin
			case (SFR_ADDR_IN)
				`SPI_ADDR_CONFIG: rdata_q <= {cfg_q.clock_phase_sel, cfg_q.clock_polarity_sel,
					bit_progress_count_q, cfg_q.frame_length_sel};
				`SPI_ADDR_DATA: rdata_q <= rx_buf_q;
				`SPI_ADDR_DIVIDER: rdata_q <= clock_divide_value_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// ***********************************************
	// outputs
	// ***********************************************
	assign SFR_RDATA_OUT = rdata_q;
	assign BUSY_OUT = busy;
	assign DONE_OUT = done_q;
	assign COLLISION_OUT = collision_q;
	assign SCK_OUT = sclk_q ^ cfg_q.clock_polarity_sel;
	assign SCK_OE_OUT = is_master & ~clash;
	assign MOSI_OUT = out_q;
	assign MOSI_OE_OUT = is_master & ~clash;
	assign MISO_OUT = out_q;
	assign MISO_OE_OUT = selected;
	assign SLAVE_SELECT_N_OUT = ~(state_q == ST_RUN);
endmodule

// ==== bench/spi_port_props.sv ====
// pin and flag checks for the serial port
// assumes binding into spi_port; register writes are mirrored here
`timescale 1ns/1ps
// ********
// checker
// ********
module spi_port_props (
	// clock, reset, mode
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic ENABLE_IN,
	input wire logic MASTER_MODE_IN,
	// register port
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic SFR_WR_IN,
	input wire logic SFR_RD_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic [7:0] SFR_RDATA_OUT,
	// flags
	input wire logic BUSY_OUT,
	input wire logic DONE_OUT,
	input wire logic COLLISION_OUT,
	input wire logic RX_VALID_OUT,
	// pins
	input wire logic SCK_OUT,
	input wire logic SCK_OE_OUT,
	input wire logic MOSI_OUT,
	input wire logic MOSI_OE_OUT,
	input wire logic MISO_OE_OUT,
	input wire logic SLAVE_SELECT_N_IN,
	input wire logic SLAVE_SELECT_N_OUT
);
	logic [7:0] cfg_q;
	logic [7:0] div_q;
	int busy_q;
	int gap_q;
	logic seen_q;
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cfg_q <= 8'h07;
			div_q <= 8'h00;
		end else if (SFR_WR_IN) begin
			if (SFR_ADDR_IN == 8'h9a)
				cfg_q <= SFR_WDATA_IN;
			if (SFR_ADDR_IN == 8'h9d)
				div_q <= SFR_WDATA_IN;
		end
	end
	// seen_q skips the first edge of a frame, whose gap is the idle time
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			busy_q <= 0;
			gap_q <= 0;
			seen_q <= 1'b0;
		end else begin
			busy_q <= BUSY_OUT ? busy_q + 1 : 0;
			gap_q <= $changed(SCK_OUT) ? 0 : gap_q + 1;
			seen_q <= BUSY_OUT && (seen_q || $changed(SCK_OUT));
		end
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	a_start_shift: assert property (SFR_WR_IN && SFR_ADDR_IN == 8'h9b && MASTER_MODE_IN && ENABLE_IN
		&& !BUSY_OUT && SLAVE_SELECT_N_IN && !RX_VALID_OUT && !cfg_q[7]
		|=> BUSY_OUT && !SLAVE_SELECT_N_OUT && MOSI_OUT == $past(SFR_WDATA_IN[7]))
		else $error("master start missing");
	a_frame_time: assert property ($rose(DONE_OUT) && MASTER_MODE_IN
		|-> busy_q == 2 * (cfg_q[2:0] + 1) * (div_q + 1))
		else $error("frame length wrong");
	a_sck_period: assert property ($changed(SCK_OUT) && BUSY_OUT && seen_q && MASTER_MODE_IN
		|-> gap_q == div_q)
		else $error("serial clock period wrong");
	a_idle_level: assert property (MASTER_MODE_IN && $past(MASTER_MODE_IN) && !BUSY_OUT
		&& $past(!BUSY_OUT) && $stable(cfg_q) |-> SCK_OUT == cfg_q[6])
		else $error("idle clock level wrong");
	a_collide_abort: assert property (MASTER_MODE_IN && ENABLE_IN && !SLAVE_SELECT_N_IN
		&& (BUSY_OUT || SFR_WR_IN && SFR_ADDR_IN == 8'h9b) |=> COLLISION_OUT && !BUSY_OUT)
		else $error("collision not flagged");
	a_slave_quiet: assert property (SLAVE_SELECT_N_IN || MASTER_MODE_IN || !ENABLE_IN |-> !MISO_OE_OUT)
		else $error("slave output not released");
	a_master_drive: assert property ((MASTER_MODE_IN && ENABLE_IN && SLAVE_SELECT_N_IN) == SCK_OE_OUT
		&& MOSI_OE_OUT == SCK_OE_OUT)
		else $error("master drive enables wrong");
	a_select_run: assert property (MASTER_MODE_IN |-> SLAVE_SELECT_N_OUT == !BUSY_OUT)
		else $error("select out wrong");
	a_done_push: assert property ($rose(DONE_OUT) && MASTER_MODE_IN |-> RX_VALID_OUT)
		else $error("word not buffered");
	a_rdata_hold: assert property (!SFR_RD_IN |=> $stable(SFR_RDATA_OUT))
		else $error("read data moved");
	c_master_done: cover property ($rose(DONE_OUT) && MASTER_MODE_IN);
	c_collision: cover property ($rose(COLLISION_OUT));
	c_slave_busy: cover property (MISO_OE_OUT && BUSY_OUT);
endmodule
bind spi_port spi_port_props u_props (.*);

// ==== bench/spi_slave_model.sv ====
// behavioural slave device on the master side of the port
// assumes the bench sets its clock polarity and phase to match the port
`timescale 1ns/1ps
// ********
// slave model
// ********
module spi_slave_model (
	// serial pins
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic ss_n_in,
	output logic miso_out,
	// mode and data
	input wire logic pol_in,
	input wire logic pha_in,
	input wire logic [7:0] tx_in,
	output logic [7:0] sr_out
);
	logic sel = 1'b0;
	initial miso_out = 1'b0;
	always @(negedge ss_n_in) begin
		sel = 1'b1;
		sr_out = tx_in;
		miso_out = tx_in[7];
	end
	// late release so a last edge in the same step still counts
	always @(posedge ss_n_in) begin
		sel <= 1'b0;
		miso_out <= !miso_out;
	end
	always @(sck_in) begin
		if (sel) begin
			if ((sck_in != pol_in) != pha_in)
				sr_out = {sr_out[6:0], mosi_in};
			else
				miso_out = sr_out[7];
		end
	end
endmodule

// ==== bench/tb.sv ====
// self-checking bench: registers, master frames, fifo, collision, slave frames
// assumes the checker binds itself and the slave model sits on the master pins
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
// ********
// bench top
// ********
module tb;
	import spi_port_pkg::*;
	logic CLK_IN = 0, NRST_IN = 0, ENABLE_IN = 0, MASTER_MODE_IN = 1, SFR_WR_IN = 0, SFR_RD_IN = 0;
	logic DONE_CLR_IN = 0, COLLISION_CLR_IN = 0, RX_READY_IN = 0, SLAVE_SELECT_N_IN = 1;
	logic [7:0] SFR_ADDR_IN = 0, SFR_WDATA_IN = 0, tx = 0, m, t, s, q;
	logic sck = 0, mosi = 0, pol = 0, pha = 0;
	logic [31:0] lf = 32'h4d714251;
	int fails = 0, comparisons = 0, cyc = 0, n;
	logic [7:0] expq[$];
	wire [7:0] SFR_RDATA_OUT, RX_DATA_OUT, sr;
	wire BUSY_OUT, DONE_OUT, COLLISION_OUT, RX_VALID_OUT, SCK_OUT, SCK_OE_OUT, MOSI_OUT, MOSI_OE_OUT;
	wire MISO_OUT, MISO_OE_OUT, SLAVE_SELECT_N_OUT, mmiso;
	wire sck_w = SCK_OE_OUT ? SCK_OUT : sck;
	wire mosi_w = MOSI_OE_OUT ? MOSI_OUT : mosi;
	wire miso_w = MISO_OE_OUT ? MISO_OUT : mmiso;
	spi_port u_dut (.*, .SCK_IN(sck_w), .MOSI_IN(mosi_w), .MISO_IN(miso_w));
	spi_slave_model u_far (.sck_in(sck_w), .mosi_in(mosi_w), .ss_n_in(MASTER_MODE_IN ? SLAVE_SELECT_N_OUT : 1'b1),
		.miso_out(mmiso), .pol_in(pol), .pha_in(pha), .tx_in(tx), .sr_out(sr));
	always #50 CLK_IN = !CLK_IN;
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			end_of_test;
		end
	end
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction
	// word after n shifts: own bits move up, n far bits enter below
	function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b, input int k);
		return (a << k) | (b >> (8 - k));
	endfunction
	task automatic cy(input int k);
		repeat (k) @(negedge CLK_IN);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		SFR_ADDR_IN = a;
		SFR_WDATA_IN = d;
		SFR_WR_IN = 1;
		cy(1);
		SFR_WR_IN = 0;
		cy(1);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		SFR_ADDR_IN = a;
		SFR_RD_IN = 1;
		cy(1);
		SFR_RD_IN = 0;
		`CHK(SFR_RDATA_OUT, e)
		cy(1);
	endtask
	// bench as external master; sck stands at idle outside frames
	task automatic xfer(input logic [7:0] d, input int h, output logic [7:0] g);
		SLAVE_SELECT_N_IN = 0;
		mosi = d[7];
		cy(h);
		for (int b = 7; b >= 0; b--) begin
			if (pha)
				mosi = d[b];
			sck = !pol;
			cy(h);
			g[b] = miso_w;
			sck = pol;
			if (!pha && b > 0)
				mosi = d[b - 1];
			cy(h);
		end
		SLAVE_SELECT_N_IN = 1;
		mosi = !mosi;
	endtask
	initial begin
		cy(5);
		NRST_IN = 1;
		ENABLE_IN = 1;
		cy(1);
		rdchk(8'h9a, 8'h07);
		rdchk(8'h9b, 8'h00);
		rdchk(8'h9d, 8'h00);
		rdchk(8'h9c, 8'h00);
		wr(8'h9a, 8'hff);
		rdchk(8'h9a, 8'hc7);
		for (int i = 0; i < 8; i++) begin
			m = rnd();
			tx = rnd();
			{pha, pol} = i[1:0];
			n = (i == 0) ? 1 : (i == 1) ? 8 : rnd() % 8 + 1;
			wr(8'h9d, (i == 7) ? 8'hff : rnd() % 4);
			DONE_CLR_IN = 1;
			wr(8'h9a, {pha, pol, 3'b000, 3'(n - 1)});
			DONE_CLR_IN = 0;
			wr(8'h9b, m);
			wr(8'h9b, ~m);
			while (BUSY_OUT !== 1'b0)
				cy(1);
			cy(1);
			t = mix(m, tx, n);
			`CHK(DONE_OUT, 1'b1)
			`CHK(sr, mix(tx, m, n))
			rdchk(8'h9b, t);
			rdchk(8'h9a, {pha, pol, 3'b000, 3'(n - 1)});
			expq.push_back(t);
		end
		DONE_CLR_IN = 1;
		wr(8'h9b, 8'h3c);
		DONE_CLR_IN = 0;
		`CHK(BUSY_OUT, 1'b0)
		while (expq.size() > 0) begin
			RX_READY_IN = rnd() > 8'h80;
			if (RX_READY_IN && RX_VALID_OUT) begin
				t = expq.pop_front();
				`CHK(RX_DATA_OUT, t)
			end
			cy(1);
		end
		`CHK(RX_VALID_OUT, 1'b0)
		RX_READY_IN = 1;
		wr(8'h9b, 8'h81);
		cy(3);
		SLAVE_SELECT_N_IN = 0;
		cy(2);
		`CHK({COLLISION_OUT, BUSY_OUT, DONE_OUT}, 3'b100)
		COLLISION_CLR_IN = 1;
		cy(1);
		COLLISION_CLR_IN = 0;
		`CHK(COLLISION_OUT, 1'b0)
		wr(8'h9b, 8'h42);
		`CHK({COLLISION_OUT, BUSY_OUT}, 2'b10)
		SLAVE_SELECT_N_IN = 1;
		MASTER_MODE_IN = 0;
		for (int i = 0; i < 4; i++) begin
			{pha, pol} = i[1:0];
			sck = pol;
			DONE_CLR_IN = 1;
			wr(8'h9a, {pha, pol, 6'h00});
			DONE_CLR_IN = 0;
			s = rnd();
			m = rnd();
			wr(8'h9b, s);
			// a rate under a tenth also stands for an unsynchronised master
			xfer(m, (i == 3) ? 1 : (i == 2) ? 6 : 5, q);
			while (DONE_OUT !== 1'b1)
				cy(1);
			rdchk(8'h9b, m);
			if (i < 3)
				`CHK(q, s)
		end
		end_of_test;
	end
endmodule
